// ---- hw/pcsr_pkg.sv ----
/*
  Constants and carrier types for the bus command and status register pair.
  Assumes a configuration port that presents decoded dword writes and reads.
*/
package pcsr_pkg;
  // ============================================================
  // Offsets
  localparam logic [7:0]  CFG_CMD_OFFSET  = 8'h04;
  localparam logic [7:0]  CFG_STAT_OFFSET = 8'h06;
  localparam logic [5:0]  CFG_CMD_DWORD   = 6'h01;
  // ============================================================
  // Command field positions
  localparam int CMD_IO_BIT   = 0;
  localparam int CMD_MEM_BIT  = 1;
  localparam int CMD_BM_BIT   = 2;
  localparam int CMD_PERR_BIT = 6;
  localparam int CMD_SERR_BIT = 8;
  localparam logic [15:0] CMD_WRITABLE = 16'h0147;
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  // ============================================================
  // Status field positions
  localparam int STAT_DPAR_BIT = 8;
  localparam int STAT_RTA_BIT  = 12;
  localparam int STAT_RMA_BIT  = 13;
  localparam int STAT_SSE_BIT  = 14;
  localparam int STAT_DPE_BIT  = 15;
  localparam logic [15:0] STAT_W1C_MASK = 16'hF100;
  localparam logic [15:0] STAT_FIXED    = 16'h0290;
  localparam logic [15:0] STAT_RESET    = 16'h0000;
  // ============================================================
  // Decode timing
  localparam int DEVSEL_DELAY_CYCLES = 2;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  dword;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } pcsr_cfg_req_t;

  typedef struct packed {
    logic addr_phase;
    logic addr_par_err;
    logic slave_wdata_xfer;
    logic slave_data_par_err;
    logic master_rd_xfer;
    logic master_rd_par_err;
    logic master_wr_xfer;
    logic target_perr_seen;
    logic master_abort;
    logic target_abort;
  } pcsr_events_t;

  typedef enum logic [1:0] {
    DS_IDLE  = 2'b00,
    DS_WAIT  = 2'b01,
    DS_CLAIM = 2'b10
  } pcsr_ds_state_t;
endpackage : pcsr_pkg

// ---- hw/pcsr_devsel_timer.sv ----
/*
  Medium decode timer: raises claim one clock after frame start, one clock ahead of the output flop.
  Assumes frame_start is a one-cycle pulse and hit is valid with it.
*/
`timescale 1ns/10ps
`default_nettype none
module pcsr_devsel_timer (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic frame_start,
  input  wire logic hit,
  input  wire logic cycle_end,
  output var  logic claim
);
  import pcsr_pkg::*;

  pcsr_ds_state_t state_reg;
  pcsr_ds_state_t state_next;
  logic [1:0]     cnt_reg;
  logic [1:0]     cnt_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      DS_IDLE: begin
        if (frame_start && hit) begin
          state_next = DS_WAIT;
          cnt_next   = 2'h1;
        end
      end
      DS_WAIT: begin
        if (cnt_reg == 2'(DEVSEL_DELAY_CYCLES - 1)) begin
          state_next = DS_CLAIM;
        end else begin
          cnt_next = 2'(cnt_reg + 2'h1);
        end
      end
      DS_CLAIM: begin
        if (cycle_end) begin
          state_next = DS_IDLE;
        end
      end
      default: state_next = DS_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg <= DS_IDLE;
      cnt_reg   <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Taken from the next state so the output flop lands on medium timing
  assign claim = (state_next == DS_CLAIM);

  chk_devsel_two_clk: assert property (@(posedge clock)
    disable iff (reset)
    (state_reg == DS_IDLE && frame_start && hit) |-> ##1 claim)
    else $error("claim not ready one clock after frame start");
endmodule : pcsr_devsel_timer
`default_nettype wire

// ---- hw/pcsr_regs.sv ----
/*
  Bus command and status registers with parity, abort and decode gating.
  Assumes the bus engine reports phase events as one-cycle pulses and
  presents configuration accesses already decoded to a dword index.
*/
`timescale 1ns/10ps
`default_nettype none
module pcsr_regs (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire pcsr_pkg::pcsr_cfg_req_t cfg_req,
  input  wire pcsr_pkg::pcsr_events_t  events,
  input  wire logic                   io_cmd_hit,
  input  wire logic                   mem_cmd_hit,
  input  wire logic                   rom_cmd_hit,
  input  wire logic                   rom_enable,
  input  wire logic                   frame_start,
  input  wire logic                   cycle_end,
  input  wire logic                   master_req,
  output logic [31:0]                 cfg_rdata,
  output logic                        perr_out,
  output logic                        serr_out,
  output logic                        devsel_out,
  output logic                        master_grant_ok,
  output logic                        io_decode_en,
  output logic                        mem_decode_en,
  output logic                        rom_decode_en
);
  import pcsr_pkg::*;

  // ============================================================
  // Register state
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic [15:0] stat_reg;
  logic [15:0] stat_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        perr_reg;
  logic        perr_next;
  logic        serr_reg;
  logic        serr_next;
  logic        gnt_reg;
  logic        gnt_next;
  logic        io_en_reg;
  logic        mem_en_reg;
  logic        rom_en_reg;
  logic        dec_next_io;
  logic        dec_next_mem;
  logic        dec_next_rom;
  logic        cmd_sel;
  logic        any_par_err;
  logic        addr_err;
  logic        data_err;
  logic        claim_hit;
  logic        claim;
  logic [15:0] set_bits;
  logic [15:0] clr_bits;

  // Expand per-byte enables into a 16-bit lane mask
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  wire logic parity_response_enable = cmd_reg[CMD_PERR_BIT];
  wire logic system_error_report_enable = cmd_reg[CMD_SERR_BIT];

  // ============================================================
  // Error detection, only at the sampling points
  always_comb begin
    addr_err = events.addr_phase && events.addr_par_err;
    data_err = (events.slave_wdata_xfer && events.slave_data_par_err)
             || (events.master_rd_xfer && events.master_rd_par_err);
    any_par_err = addr_err || data_err
                || (events.master_wr_xfer && events.target_perr_seen);
  end

  // ============================================================
  // Command and status next values
  always_comb begin
    cmd_sel  = cfg_req.wr && (cfg_req.dword == CFG_CMD_DWORD);
    cmd_next = cmd_reg;
    if (cmd_sel) begin
      // Reserved and hardwired-zero bits never take a write
      cmd_next = (cmd_reg & ~(CMD_WRITABLE & lane_mask(cfg_req.byte_en[1:0])))
               | (cfg_req.wdata[15:0] & CMD_WRITABLE
                  & lane_mask(cfg_req.byte_en[1:0]));
    end

    set_bits = 16'h0000;
    set_bits[STAT_DPE_BIT] = any_par_err;
    set_bits[STAT_SSE_BIT] = addr_err && system_error_report_enable && parity_response_enable;
    set_bits[STAT_RMA_BIT] = events.master_abort;
    set_bits[STAT_RTA_BIT] = events.target_abort;
    set_bits[STAT_DPAR_BIT] = parity_response_enable
      && ((events.master_rd_xfer && events.master_rd_par_err)
          || (events.master_wr_xfer && events.target_perr_seen));

    clr_bits = 16'h0000;
    if (cmd_sel) begin
      clr_bits = cfg_req.wdata[31:16] & STAT_W1C_MASK
               & lane_mask(cfg_req.byte_en[3:2]);
    end
    // A new event beats a clear in the same cycle
    stat_next = ((stat_reg & ~clr_bits) | set_bits) & STAT_W1C_MASK;
  end

  // ============================================================
  // Pin drive, grant and decode gating
  always_comb begin
    perr_next = parity_response_enable && data_err;
    serr_next = addr_err && system_error_report_enable && parity_response_enable;
    gnt_next  = master_req && cmd_reg[CMD_BM_BIT];
    dec_next_io  = cmd_reg[CMD_IO_BIT];
    dec_next_mem = cmd_reg[CMD_MEM_BIT];
    dec_next_rom = cmd_reg[CMD_MEM_BIT] && rom_enable;
    rdata_next = rdata_reg;
    if (cfg_req.rd) begin
      rdata_next = 32'h0000_0000;
      if (cfg_req.dword == CFG_CMD_DWORD) begin
        rdata_next = {stat_reg | STAT_FIXED, cmd_reg};
      end
    end
  end

  // Claim only when the matching space is enabled
  assign claim_hit = (io_cmd_hit && cmd_reg[CMD_IO_BIT])
                   || (mem_cmd_hit && cmd_reg[CMD_MEM_BIT])
                   || (rom_cmd_hit && rom_enable && cmd_reg[CMD_MEM_BIT]);

  pcsr_devsel_timer u_devsel (
    .clock       (clock),
    .reset       (reset),
    .frame_start (frame_start),
    .hit         (claim_hit),
    .cycle_end   (cycle_end),
    .claim       (claim)
  );

  // ============================================================
  // Flops: hardware reset only; soft reset never reaches here
  logic devsel_reg;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cmd_reg    <= CMD_RESET;
      stat_reg   <= STAT_RESET;
      rdata_reg  <= 32'h0000_0000;
      perr_reg   <= 1'b0;
      serr_reg   <= 1'b0;
      gnt_reg    <= 1'b0;
      io_en_reg  <= 1'b0;
      mem_en_reg <= 1'b0;
      rom_en_reg <= 1'b0;
      devsel_reg <= 1'b0;
    end else begin
      cmd_reg    <= cmd_next;
      stat_reg   <= stat_next;
      rdata_reg  <= rdata_next;
      perr_reg   <= perr_next;
      serr_reg   <= serr_next;
      gnt_reg    <= gnt_next;
      io_en_reg  <= dec_next_io;
      mem_en_reg <= dec_next_mem;
      rom_en_reg <= dec_next_rom;
      devsel_reg <= claim;
    end
  end

  assign cfg_rdata       = rdata_reg;
  assign perr_out        = perr_reg;
  assign serr_out        = serr_reg;
  assign master_grant_ok = gnt_reg;
  assign io_decode_en    = io_en_reg;
  assign mem_decode_en   = mem_en_reg;
  assign rom_decode_en   = rom_en_reg;
  assign devsel_out      = devsel_reg;

  // ============================================================
  // Checks
  chk_serr_needs_enables: assert property (@(posedge clock)
    disable iff (reset) serr_out |-> $past(system_error_report_enable && parity_response_enable))
    else $error("system error pin without both enables");

  chk_serr_on_addr: assert property (@(posedge clock)
    disable iff (reset) (addr_err && system_error_report_enable && parity_response_enable) |=> serr_out)
    else $error("system error pin missing");

  chk_perr_pin_gated: assert property (@(posedge clock)
    disable iff (reset) perr_out |-> $past(parity_response_enable))
    else $error("parity pin with response disabled");

  chk_perr_on_data: assert property (@(posedge clock)
    disable iff (reset) (parity_response_enable && data_err) |=> perr_out)
    else $error("parity pin missing");

  chk_dpe_on_error: assert property (@(posedge clock)
    disable iff (reset) any_par_err |=> stat_reg[STAT_DPE_BIT])
    else $error("detected parity bit not set");

  chk_sse_gated: assert property (@(posedge clock)
    disable iff (reset)
    $rose(stat_reg[STAT_SSE_BIT]) |-> $past(system_error_report_enable && parity_response_enable && addr_err))
    else $error("signaled error bit set without cause");

  chk_abort_flags: assert property (@(posedge clock)
    disable iff (reset)
    events.master_abort |=> stat_reg[STAT_RMA_BIT])
    else $error("master abort not recorded");

  chk_tabort_flag: assert property (@(posedge clock)
    disable iff (reset)
    events.target_abort |=> stat_reg[STAT_RTA_BIT])
    else $error("target abort not recorded");

  chk_fixed_bits: assert property (@(posedge clock)
    disable iff (reset)
    (cmd_reg & ~CMD_WRITABLE) == 16'h0000
    && (stat_reg & ~STAT_W1C_MASK) == 16'h0000)
    else $error("fixed bits changed");

  chk_master_gate: assert property (@(posedge clock)
    disable iff (reset)
    master_grant_ok |-> $past(cmd_reg[CMD_BM_BIT]))
    else $error("mastering without bus master enable");

  chk_dpar_flag: assert property (@(posedge clock)
    disable iff (reset)
    (events.master_wr_xfer && events.target_perr_seen && parity_response_enable)
    |=> stat_reg[STAT_DPAR_BIT] && stat_reg[STAT_DPE_BIT])
    else $error("target parity report not recorded");

  // Decode timing: claim shows two clocks after the sampled frame start
  chk_devsel_medium: assert property (@(posedge clock)
    disable iff (reset)
    $rose(devsel_out) |-> $past(frame_start && claim_hit, 2))
    else $error("claim not at medium decode timing");

  chk_cmd_write_only: assert property (@(posedge clock)
    disable iff (reset) !cmd_sel |=> $stable(cmd_reg))
    else $error("command changed without a write");

  chk_w1c_clear: assert property (@(posedge clock)
    disable iff (reset)
    (cmd_sel && cfg_req.byte_en[3] && cfg_req.wdata[29]
     && !events.master_abort) |=> !stat_reg[STAT_RMA_BIT])
    else $error("master abort bit not cleared");
endmodule : pcsr_regs
`default_nettype wire

// ---- test/pcsr_bus_agent.sv ----
/*
  Far-side bus agent: raises phase event pulses and frame starts.
  Assumes the bench calls its tasks from the clock domain only.
*/
`timescale 1ns/10ps
`default_nettype none
module pcsr_bus_agent (
  input  wire logic             clock,
  output var  pcsr_pkg::pcsr_events_t events,
  output var  logic             frame_start,
  output var  logic             cycle_end,
  output var  logic [2:0]       hits
);
  import pcsr_pkg::*;
  initial begin
    events      = '0;
    frame_start = 1'b0;
    cycle_end   = 1'b0;
    hits        = 3'h0;
  end
  // ============================================================
  // One-cycle event pulse at a checked phase
  task automatic pulse(input pcsr_events_t ev);
    @(posedge clock);
    events <= ev;
    @(posedge clock);
    events <= '0;
  endtask : pulse
  // ============================================================
  // Address phase with decode hits, then end of cycle
  task automatic frame(input logic [2:0] h);
    @(posedge clock);
    frame_start <= 1'b1;
    hits        <= h;
    @(posedge clock);
    frame_start <= 1'b0;
    hits        <= ~h; // Hits mean nothing once frame start has gone
    repeat (6) @(posedge clock);
    cycle_end <= 1'b1;
    @(posedge clock);
    cycle_end <= 1'b0;
  endtask : frame
endmodule : pcsr_bus_agent
`default_nettype wire

// ---- test/pci_cmd_status_regs_tb.sv ----
/*
  Self-checking bench for the command and status register pair.
  Assumes pcsr_bus_agent stands in for the bus engine and far side.
*/
`timescale 1ns/10ps
`default_nettype none
module pci_cmd_status_regs_tb;
  import pcsr_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic rom_enable = 1'b1;
  logic master_req = 1'b0;
  logic [31:0] cfg_rdata, p_cnt = '0, s_cnt = '0;
  logic perr_out, serr_out, devsel_out, master_grant_ok;
  logic io_en, mem_en, rom_en, frame_start, cycle_end;
  logic [2:0] hits;
  logic [15:0] cmd_exp = 16'h0000;
  pcsr_cfg_req_t req = '0;
  pcsr_events_t events;
  int mismatches = 0, total_checks = 0;

  initial begin
    forever #4 clock = ~clock;
  end
  pcsr_bus_agent agent (.clock(clock), .events(events),
    .frame_start(frame_start), .cycle_end(cycle_end), .hits(hits));
  pcsr_regs dut (.clock(clock), .reset(reset), .cfg_req(req),
    .events(events), .io_cmd_hit(hits[0]), .mem_cmd_hit(hits[1]),
    .rom_cmd_hit(hits[2]), .rom_enable(rom_enable),
    .frame_start(frame_start), .cycle_end(cycle_end),
    .master_req(master_req), .cfg_rdata(cfg_rdata),
    .perr_out(perr_out), .serr_out(serr_out), .devsel_out(devsel_out),
    .master_grant_ok(master_grant_ok), .io_decode_en(io_en),
    .mem_decode_en(mem_en), .rom_decode_en(rom_en));
  // Pin pulses counted so width and count are both judged
  always @(posedge clock) begin
    p_cnt <= p_cnt + perr_out;
    s_cnt <= s_cnt + serr_out;
  end
  // ============================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cw(input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, dword: 6'h01, byte_en: be, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask : cw
  task automatic rc(input logic [31:0] exp);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, dword: 6'h01, byte_en: 4'hF, wdata: '0};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
    #1 chk(cfg_rdata, exp);
  endtask : rc
  // Event, pin pulse counts, write-zero, status set, then clear
  task automatic ev(input logic [9:0] e, input logic [15:0] st,
                    input logic [31:0] np, input logic [31:0] ns);
    logic [31:0] p0, s0;
    p0 = p_cnt;
    s0 = s_cnt;
    agent.pulse(e);
    repeat (3) @(posedge clock);
    chk(p_cnt - p0, np);
    chk(s_cnt - s0, ns);
    cw(4'hF, {16'h0000, cmd_exp});
    rc({st | 16'h0290, cmd_exp});
    cw(4'hC, {st, 16'hFFFF});
    rc({16'h0290, cmd_exp});
  endtask : ev
  // Frame with hits; edges until the claim shows, 8 if none
  task automatic dv(input logic [2:0] h, input logic [31:0] exp);
    logic [31:0] n;
    n = 0;
    fork
      agent.frame(h);
      begin
        @(posedge clock);
        do begin
          @(posedge clock);
          #1 n++;
        end while (devsel_out !== 1'b1 && n < 8);
      end
    join
    chk(n, exp);
  endtask : dv
  // Mid-run hardware reset clears enables and sticky status
  task automatic hard_reset;
    agent.pulse(10'h002);
    rc(32'h2290_0147);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rc(32'h0290_0000);
    chk({io_en, mem_en, rom_en, master_grant_ok}, 4'h0);
  endtask : hard_reset
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // ============================================================
  // Main sequence; event codes are packed struct bit positions
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rc(32'h0290_0000);
    dv(3'h7, 8);
    ev(10'h030, 16'h8000, 0, 0);
    ev(10'h300, 16'h8000, 0, 0);
    cw(4'hF, 32'hFFFF_FFFF);
    cmd_exp = 16'h0147;
    rc(32'h0290_0147);
    cw(4'h2, 32'h0000_0000);
    cmd_exp = 16'h0047;
    rc(32'h0290_0047);
    ev(10'h300, 16'h8000, 0, 0);
    cw(4'h3, 32'h0000_0147);
    cmd_exp = 16'h0147;
    ev(10'h300, 16'hC000, 0, 1);
    ev(10'h030, 16'h8100, 1, 0);
    ev(10'h0C0, 16'h8000, 1, 0);
    ev(10'h00C, 16'h8100, 0, 0);
    ev(10'h002, 16'h2000, 0, 0);
    ev(10'h001, 16'h1000, 0, 0);
    hard_reset();
    cw(4'h3, 32'h0000_0147);
    master_req <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({io_en, mem_en, rom_en}, 3'h7);
    dv(3'h1, 2);
    dv(3'h2, 2);
    rom_enable <= 1'b0;
    dv(3'h4, 8);
    chk(rom_en, 1'b0);
    rom_enable <= 1'b1;
    dv(3'h4, 2);
    chk(master_grant_ok, 1'b1);
    cw(4'h3, 32'h0000_0000);
    repeat (2) @(posedge clock);
    #1 chk({io_en, mem_en, rom_en, master_grant_ok}, 4'h0);
    dv(3'h2, 8);
    dv(3'h1, 8);
    summarize();
  end
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule : pci_cmd_status_regs_tb
`default_nettype wire
